/* File: dv/cdb_disp_model.sv */
// Behavioural display module that answers read transfers.
// Assumes the bench tells it the strobe polarity and bus width in use.
`timescale 1ns/1ps
module cdb_disp_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Display bus
  input wire logic strobe,
  input wire logic oe,
  output logic [7:0] data_o,
  // Bench settings
  input wire logic pol,
  input wire logic wide,
  input wire logic slow,
  input wire logic hush,
  input wire logic [7:0] rd_byte
);
  logic [7:0] pat;
  logic [1:0] age;
  logic lo_half;
  wire logic rd_act = strobe === pol && !oe && !hush;
  wire logic [7:0] nib = lo_half ? {rd_byte[3:0], pat[3:0]} : {rd_byte[7:4], pat[3:0]};
  // A slow device shows its data only some clocks into the strobe.
  wire logic ready = rd_act && (!slow || age == 2'h3);
  // Outside a read the lines carry a moving pattern; only reset holds it at 8'h5a.
  always_ff @(posedge clk)
  begin
    pat <= srst ? 8'h5a : pat + 8'h37;
    age <= rd_act ? (age == 2'h3 ? age : age + 2'h1) : 2'h0;
    lo_half <= (srst || wide || hush) ? 1'b0 : ((age != 2'h0 && !rd_act) ? !lo_half : lo_half);
    data_o <= ready ? (wide ? rd_byte : nib) : pat;
  end
endmodule : cdb_disp_model

/* File: dv/cdb_top_chk.sv */
// Concurrent checks on the display controller top ports.
// Assumes configuration is rewritten only while the display bus is idle.
`timescale 1ns/1ps
module cdb_top_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Display side
  input wire logic DMA_REQ,
  input wire logic DISPLAY_STROBE,
  input wire logic REGISTER_SELECT_LINE,
  input wire logic [7:0] DISPLAY_DATA_PINS_O,
  input wire logic DISPLAY_DATA_PINS_OE,
  input wire logic [7:0] DISPLAY_DATA_PINS_I
);
  import cdb_pkg::*;
  logic [31:0] cfg;
  logic [2:0] quiet;
  logic [13:0] cnt_a;
  logic [13:0] cnt_s;
  logic [13:0] cnt_i;
  wire logic act = DISPLAY_STROBE == cfg[CDB_CFG_POL_BIT];
  wire logic cfg_wr = PSEL && PENABLE && PWRITE && !PREADY && PADDR == CDB_OFS_CFG;
  wire logic cmd_wr = PSEL && PENABLE && PWRITE && !PREADY && PADDR == CDB_OFS_WR && PWDATA[CDB_CMD_BIT];
  wire logic [13:0] act_len = CDB_ACT_MUL * ({6'h00, cfg[31:24]} + CDB_CNT_ONE);
  wire logic [13:0] setup = {10'h000, cfg[15:12]} + CDB_CNT_ONE;
  wire logic [13:0] hold = {10'h000, cfg[11:8]} + CDB_CNT_ONE;
  wire logic [13:0] gap = CDB_INACT_MUL * ({6'h00, cfg[23:16]} + CDB_CNT_ONE) + hold;
  // A polarity change flips the idle level, so the counters rest a few clocks after any configuration write.
  always_ff @(posedge CLK)
  begin
    cfg <= SRST ? CDB_CFG_RESET : (cfg_wr ? PWDATA & CDB_CFG_WMASK : cfg);
    quiet <= SRST ? 3'h0 : (cfg_wr ? 3'h4 : (quiet != 3'h0 ? quiet - 3'h1 : quiet));
  end
  always_ff @(posedge CLK)
  begin
    cnt_a <= (SRST || quiet != 3'h0 || !act) ? 14'h0000 : cnt_a + 14'h0001;
    cnt_s <= (SRST || quiet != 3'h0 || act || !DISPLAY_DATA_PINS_OE) ? 14'h0000 : cnt_s + 14'h0001;
    cnt_i <= (SRST || quiet != 3'h0) ? 14'h3fff : (act ? 14'h0000 : (&cnt_i ? cnt_i : cnt_i + 14'h0001));
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (SRST || quiet != 3'h0);
  a_active_len: assert property ($fell(act) |-> cnt_a == act_len)
    else $error("strobe active time wrong");
  a_setup_len: assert property ($rose(act) && DISPLAY_DATA_PINS_OE |-> cnt_s == setup)
    else $error("setup time wrong");
  a_hold_len: assert property ($fell(DISPLAY_DATA_PINS_OE) |-> cnt_i == hold)
    else $error("hold time wrong");
  a_inact_gap: assert property ($rose(act) |-> cnt_i >= gap)
    else $error("strobe inactive gap too short");
  a_data_steady: assert property (DISPLAY_DATA_PINS_OE && $past(DISPLAY_DATA_PINS_OE)
    |-> $stable(DISPLAY_DATA_PINS_O) && $stable(REGISTER_SELECT_LINE))
    else $error("select or data moved during transfer");
  a_low_nibble: assert property (DISPLAY_DATA_PINS_OE && !cfg[CDB_CFG_WIDTH_BIT]
    |-> DISPLAY_DATA_PINS_O[3:0] == 4'h0)
    else $error("low data lines used in narrow mode");
  a_dma_gate: assert property (DMA_REQ |-> cfg[CDB_CFG_DMA_BIT])
    else $error("dma request while disabled");
  a_dma_drop: assert property (cmd_wr |=> !DMA_REQ)
    else $error("dma request kept with write pending");
  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("bus answer timing wrong");
endmodule : cdb_top_chk

/* File: dv/tb_cdb_top.sv */
// Self-checking bench for the display bus controller with a display model.
// Assumes the checker module is compiled before this file.
`timescale 1ns/1ps
module tb_cdb_top;
  import cdb_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, dma_req, strobe, rs, oe;
  logic pol, wide, slow, hush, act_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, r, c;
  logic [7:0] dout, din, mbyte;
  logic [33:0] apbq[$];
  logic [9:0] busq[$];
  logic [33:0] e;
  logic [9:0] x;
  int err_count, checked, seed, i;
  cdb_top dut_u (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DMA_REQ(dma_req),
    .DISPLAY_STROBE(strobe), .REGISTER_SELECT_LINE(rs), .DISPLAY_DATA_PINS_O(dout),
    .DISPLAY_DATA_PINS_OE(oe), .DISPLAY_DATA_PINS_I(din));
  cdb_disp_model disp_u (.clk(clk), .srst(srst), .strobe(strobe), .oe(oe), .data_o(din), .pol(pol),
    .wide(wide), .slow(slow), .hush(hush), .rd_byte(mbyte));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic care,
    input logic [32:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    apbq.push_back({care, exp});
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    if (n >= 16)
    begin
      err_count++;
      summarize();
    end
    @(negedge clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb
  task automatic poll(input logic [11:0] a);
    int n;
    n = 0;
    rdv = 32'h00000200;
    while (rdv[9] !== 1'b0 && n < 400)
    begin
      apb(1'b0, a, 32'h0, 1'b0, 33'h0);
      n++;
    end
    if (n >= 400)
    begin
      err_count++;
      summarize();
    end
  endtask : poll
  // Narrow mode splits every command into two transfers, upper nibble first.
  task automatic plan(input logic o, input logic s, input logic [7:0] d);
    if (wide)
      busq.push_back({o, s, d});
    else
    begin
      busq.push_back({o, s, d[7:4], 4'h0});
      busq.push_back({o, s, d[3:0], 4'h0});
    end
  endtask : plan
  always @(posedge clk)
  begin
    act_q <= strobe === pol;
    if (pready === 1'b1 && apbq.size() > 0)
    begin
      e = apbq.pop_front();
      if (e[33])
        chk("register answer", e[32:0], {pslverr, prdata});
    end
    // Read transfers are judged on direction and select only.
    if (strobe === pol && !act_q && !hush && !srst)
    begin
      x = busq.size() > 0 ? busq.pop_front() : 10'h3ff;
      chk("display transfer", {23'h0, x[9:8], x[9] ? x[7:0] : dout}, {23'h0, oe, rs, dout});
    end
  end
  initial
  begin
    seed = 32'h131c;
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pol, wide, slow, hush, mbyte} = '0;
    err_count = 0;
    checked = 0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    apb(1'b0, CDB_OFS_CFG, 32'h0, 1'b1, {1'b0, CDB_CFG_RESET});
    apb(1'b0, CDB_OFS_RD, 32'h0, 1'b1, 33'h0);
    apb(1'b1, 12'h00c, 32'hffffffff, 1'b1, {1'b1, 32'h0});
    for (i = 0; i < 4; i++)
    begin
      r = $random(seed);
      c = {8'h03, 7'h00, r[0], r[7:4], r[11:8], 5'h1f, i[1] ^ i[0], i[1], i[0]};
      hush = 1'b1;
      apb(1'b1, CDB_OFS_CFG, c, 1'b1, 33'h0);
      repeat (4) @(negedge clk);
      pol = i[0];
      wide = i[1];
      slow = r[12];
      hush = 1'b0;
      apb(1'b0, CDB_OFS_CFG, 32'h0, 1'b1, {1'b0, c & CDB_CFG_WMASK});
      chk("dma request", {32'h0, c[2]}, {32'h0, dma_req});
      plan(1'b1, r[13], r[23:16]);
      apb(1'b1, CDB_OFS_WR, {22'h0, 1'b1, r[13], r[23:16]}, 1'b1, 33'h0);
      // A second command while one is pending must be dropped.
      apb(1'b1, CDB_OFS_WR, {22'h0, 1'b1, ~r[13], ~r[23:16]}, 1'b1, 33'h0);
      apb(1'b0, CDB_OFS_WR, 32'h0, 1'b1, {23'h0, 1'b1, r[13], r[23:16]});
      chk("dma request", 33'h0, {32'h0, dma_req});
      mbyte = r[31:24];
      plan(1'b0, r[14], r[31:24]);
      apb(1'b1, CDB_OFS_RD, {22'h0, 1'b1, r[14], 8'h00}, 1'b1, 33'h0);
      poll(CDB_OFS_RD);
      chk("transfers left", 33'h0, {1'b0, busq.size()});
      apb(1'b0, CDB_OFS_RD, 32'h0, 1'b1, {24'h0, r[14], r[31:24]});
      poll(CDB_OFS_WR);
    end
    summarize();
  end
endmodule : tb_cdb_top
bind cdb_top cdb_top_chk chk_u (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
  .PSLVERR, .DMA_REQ, .DISPLAY_STROBE, .REGISTER_SELECT_LINE, .DISPLAY_DATA_PINS_O, .DISPLAY_DATA_PINS_OE,
  .DISPLAY_DATA_PINS_I);

/* File: inc/cdb_if.sv */
// Valid/ready stream carrier between the controller and its write buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cdb_if #(
  parameter int W = 9
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport buffer (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
  modport user (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
endinterface : cdb_if

/* File: inc/cdb_pkg.sv */
// Shared constants for the character display bus controller.
// Assumes a single system clock; all timing is counted in those clocks.
package cdb_pkg;
  // Register byte offsets on the peripheral bus.
  localparam logic [11:0] CDB_OFS_CFG = 12'h000;
  localparam logic [11:0] CDB_OFS_RD = 12'h004;
  localparam logic [11:0] CDB_OFS_WR = 12'h008;
  // Configuration field positions.
  localparam int CDB_CFG_ACT_HI = 31;
  localparam int CDB_CFG_ACT_LO = 24;
  localparam int CDB_CFG_INACT_HI = 23;
  localparam int CDB_CFG_INACT_LO = 16;
  localparam int CDB_CFG_SETUP_HI = 15;
  localparam int CDB_CFG_SETUP_LO = 12;
  localparam int CDB_CFG_HOLD_HI = 11;
  localparam int CDB_CFG_HOLD_LO = 8;
  localparam int CDB_CFG_DMA_BIT = 2;
  localparam int CDB_CFG_WIDTH_BIT = 1;
  localparam int CDB_CFG_POL_BIT = 0;
  // Command register field positions.
  localparam int CDB_CMD_BIT = 9;
  localparam int CDB_RS_BIT = 8;
  // Values after reset, and the configuration write mask.
  localparam logic [31:0] CDB_CFG_RESET = 32'hffffff00;
  localparam logic [31:0] CDB_CFG_WMASK = 32'hffffff07;
  localparam logic [8:0] CDB_WR_RESET = 9'h000;
  localparam logic [7:0] CDB_BYTE_RESET = 8'h00;
  // Cycle multipliers for the strobe intervals.
  localparam logic [13:0] CDB_ACT_MUL = 14'h0002;
  localparam logic [13:0] CDB_INACT_MUL = 14'h0020;
  localparam logic [13:0] CDB_CNT_ONE = 14'h0001;
  // Depth of the write command buffer.
  localparam int CDB_FIFO_DEPTH = 4;
  localparam int CDB_ENTRY_W = 9;

  typedef enum logic [4:0] {
    CDB_IDLE = 5'h01,
    CDB_SETUP = 5'h02,
    CDB_ACTIVE = 5'h04,
    CDB_HOLD = 5'h08,
    CDB_INACT = 5'h10
  } cdb_state_t;
endpackage : cdb_pkg

/* File: verilog/cdb_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cdb_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic srst,
  cdb_if.buffer port
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire push = port.in_valid && port.in_ready;
  wire pop = port.out_valid && port.out_ready;

  assign port.in_ready = (count != DEPTH[AW:0]);
  assign port.out_valid = (count != '0);
  assign port.out_data = mem[rptr];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr] <= port.in_data;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      if (pop)
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : cdb_fifo

/* File: verilog/cdb_top.sv */
// Character display bus controller: peripheral bus registers and display cycle engine.
// Assumes an APB master on CLK and an external display module on the data pins.
//
// How it works
// - Writes run automatically when pending and no read pending; reads go first.
// - A pending read command launches a display read cycle.
// - Configuration bit 0 picks strobe active level, set means high.
// - In 8-bit width each command is one 8-bit transfer.
// - In 4-bit width, two transfers, upper nibble first, on data lines 7:4.
// - With DMA enabled, request asserted whenever no write command is pending.
// - Strobe active lasts 2 x (field+1) clocks, field at bits 31:24.
// - Strobe inactive lasts at least 32 x (field+1) clocks, field at 23:16.
// - Select and data are stable (field+1) clocks before strobe activates.
// - Select and data are held (field+1) clocks after strobe deactivates.
// - Configuration bit 1 selects 8-bit width when set, 4-bit when clear.
// - Read command bit 9 starts a read, reads 1 until done, then clears.
// - During a read, the select pin follows read register bit 8.
// - Captured read byte is stored in read register bits 7:0.
// - Write command bit 9 marks a pending write, clears when done.
// - During a write, the select pin follows write register bit 8.
// - During a write, write register bits 7:0 drive the data pins.
`timescale 1ns/1ps
module cdb_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // DMA request
  output logic DMA_REQ,
  // Display pins
  output logic DISPLAY_STROBE,
  output logic REGISTER_SELECT_LINE,
  output logic [7:0] DISPLAY_DATA_PINS_O,
  output logic DISPLAY_DATA_PINS_OE,
  input wire logic [7:0] DISPLAY_DATA_PINS_I
);
  import cdb_pkg::*;

  // Register state.
  logic [31:0] cfg;
  logic rd_cmd;
  logic rd_rs;
  logic [7:0] display_byte;
  logic [8:0] wr_shadow;

  // Engine state.
  cdb_state_t state;
  cdb_state_t next_state;
  logic [13:0] cnt;
  logic [13:0] next_cnt;
  logic op_read;
  logic op_rs;
  logic [7:0] op_data;
  logic second_nibble;
  logic wr_busy;

  // Synchroniser for the display data inputs.
  logic [7:0] din_meta;
  logic [7:0] din_sync;

  // Write command buffer.
  cdb_if #(.W(CDB_ENTRY_W)) wq ();

  cdb_fifo #(
    .W(CDB_ENTRY_W),
    .DEPTH(CDB_FIFO_DEPTH)
  ) u_wq (
    .clk(CLK),
    .srst(SRST),
    .port(wq)
  );

  // Configuration decode.
  wire pol = cfg[CDB_CFG_POL_BIT];
  wire wide = cfg[CDB_CFG_WIDTH_BIT];
  wire dma_en = cfg[CDB_CFG_DMA_BIT];
  wire [13:0] setup_len = {10'h000, cfg[CDB_CFG_SETUP_HI:CDB_CFG_SETUP_LO]} + CDB_CNT_ONE;
  wire [13:0] hold_len = {10'h000, cfg[CDB_CFG_HOLD_HI:CDB_CFG_HOLD_LO]} + CDB_CNT_ONE;
  wire [13:0] act_field = {6'h00, cfg[CDB_CFG_ACT_HI:CDB_CFG_ACT_LO]} + CDB_CNT_ONE;
  wire [13:0] inact_field = {6'h00, cfg[CDB_CFG_INACT_HI:CDB_CFG_INACT_LO]} + CDB_CNT_ONE;
  wire [27:0] act_prod = act_field * CDB_ACT_MUL;
  wire [27:0] inact_prod = inact_field * CDB_INACT_MUL;
  wire [13:0] act_len = act_prod[13:0];
  wire [13:0] inact_len = inact_prod[13:0];

  // Bus decode. Answers take one wait state so that read data come from a register.
  wire access = PSEL && PENABLE && !PREADY;
  wire hit_cfg = (PADDR == CDB_OFS_CFG);
  wire hit_rd = (PADDR == CDB_OFS_RD);
  wire hit_wr = (PADDR == CDB_OFS_WR);
  wire mapped = hit_cfg || hit_rd || hit_wr;
  wire bus_wr = access && PWRITE;
  wire wr_cfg = bus_wr && hit_cfg;
  wire wr_rd = bus_wr && hit_rd;
  wire wr_wr = bus_wr && hit_wr;
  // A command written while one is still set is dropped; software must poll first.
  wire wr_pending = wq.out_valid || wr_busy;
  wire rd_start = wr_rd && PWDATA[CDB_CMD_BIT] && !rd_cmd;
  wire wr_push_req = wr_wr && PWDATA[CDB_CMD_BIT] && !wr_pending;
  wire [31:0] rd_mux = hit_cfg ? cfg :
                       hit_rd ? {22'h000000, rd_cmd, rd_rs, display_byte} :
                       hit_wr ? {22'h000000, wr_pending, wr_shadow} : 32'h00000000;

  assign wq.in_valid = wr_push_req;
  assign wq.in_data = PWDATA[8:0];

  // Engine decode.
  wire cnt_done = (cnt == CDB_CNT_ONE);
  wire last_nibble = wide || second_nibble;
  wire start_read = (state == CDB_IDLE) && rd_cmd;
  wire start_write = (state == CDB_IDLE) && !rd_cmd && wq.out_valid;
  wire done = (state == CDB_INACT) && cnt_done && last_nibble;
  // The queue is drained only when the engine can take the entry; a busy engine stalls it.
  assign wq.out_ready = start_write;
  wire [7:0] wq_byte = wq.out_data[7:0];
  wire wq_rs = wq.out_data[CDB_RS_BIT];
  // Narrow mode moves the low nibble up for the second transfer.
  wire [7:0] pin_byte = wide ? op_data :
                        second_nibble ? {op_data[3:0], 4'h0} : {op_data[7:4], 4'h0};
  wire [7:0] cap_byte = wide ? din_sync :
                        second_nibble ? {display_byte[7:4], din_sync[7:4]} :
                        {din_sync[7:4], display_byte[3:0]};
  wire drive_bus = !op_read && ((state == CDB_SETUP) || (state == CDB_ACTIVE) ||
                                (state == CDB_HOLD));
  // The strobe lags the state by one clock, as select and data do, so every interval keeps its full length.
  wire strobe_on = (state == CDB_ACTIVE);

  // Sequencer: setup, active, hold, inactive for every transfer.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      CDB_IDLE:
      begin
        if (start_read || start_write)
        begin
          next_state = CDB_SETUP;
          next_cnt = setup_len;
        end
      end
      CDB_SETUP:
      begin
        if (cnt_done)
        begin
          next_state = CDB_ACTIVE;
          next_cnt = act_len;
        end
        else
          next_cnt = cnt - CDB_CNT_ONE;
      end
      CDB_ACTIVE:
      begin
        if (cnt_done)
        begin
          next_state = CDB_HOLD;
          next_cnt = hold_len;
        end
        else
          next_cnt = cnt - CDB_CNT_ONE;
      end
      CDB_HOLD:
      begin
        if (cnt_done)
        begin
          next_state = CDB_INACT;
          next_cnt = inact_len;
        end
        else
          next_cnt = cnt - CDB_CNT_ONE;
      end
      CDB_INACT:
      begin
        if (cnt_done && last_nibble)
        begin
          next_state = CDB_IDLE;
          next_cnt = CDB_CNT_ONE;
        end
        else if (cnt_done)
        begin
          next_state = CDB_SETUP;
          next_cnt = setup_len;
        end
        else
          next_cnt = cnt - CDB_CNT_ONE;
      end
      default:
      begin
        next_state = CDB_IDLE;
        next_cnt = CDB_CNT_ONE;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state <= CDB_IDLE;
      cnt <= CDB_CNT_ONE;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Operation latched at launch so that command register writes cannot disturb a cycle; configuration is used live.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      op_read <= 1'b0;
      op_rs <= 1'b0;
      op_data <= CDB_BYTE_RESET;
      wr_busy <= 1'b0;
    end
    else if (start_read)
    begin
      op_read <= 1'b1;
      op_rs <= rd_rs;
      wr_busy <= 1'b0;
    end
    else if (start_write)
    begin
      op_read <= 1'b0;
      op_rs <= wq_rs;
      op_data <= wq_byte;
      wr_busy <= 1'b1;
    end
    else if (done)
      wr_busy <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      second_nibble <= 1'b0;
    else if (state == CDB_IDLE)
      second_nibble <= 1'b0;
    else if ((state == CDB_INACT) && cnt_done && !wide)
      second_nibble <= 1'b1;
  end

  // Two flip-flops before the read data reach any logic.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      din_meta <= CDB_BYTE_RESET;
      din_sync <= CDB_BYTE_RESET;
    end
    else
    begin
      din_meta <= DISPLAY_DATA_PINS_I;
      din_sync <= din_meta;
    end
  end

  // Configuration register.
  always_ff @(posedge CLK)
  begin
    if (SRST)
      cfg <= CDB_CFG_RESET;
    else if (wr_cfg)
      cfg <= PWDATA & CDB_CFG_WMASK;
  end

  // Read command register; data are sampled in the last clock of the active state.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rd_cmd <= 1'b0;
      rd_rs <= 1'b0;
      display_byte <= CDB_BYTE_RESET;
    end
    else
    begin
      if (rd_start)
        rd_cmd <= 1'b1;
      else if (done && op_read)
        rd_cmd <= 1'b0;
      if (wr_rd && !rd_cmd)
        rd_rs <= PWDATA[CDB_RS_BIT];
      if (op_read && (state == CDB_ACTIVE) && cnt_done)
        display_byte <= cap_byte;
    end
  end

  // Write register shadow, read back by software.
  always_ff @(posedge CLK)
  begin
    if (SRST)
      wr_shadow <= CDB_WR_RESET;
    else if (wr_wr && !wr_pending)
      wr_shadow <= PWDATA[8:0];
  end

  // Bus answer.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= access;
      PRDATA <= (access && !PWRITE) ? rd_mux : 32'h00000000;
      PSLVERR <= access && !mapped;
    end
  end

  // Registered pin drivers.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      DISPLAY_STROBE <= 1'b1;
      REGISTER_SELECT_LINE <= 1'b0;
      DISPLAY_DATA_PINS_O <= CDB_BYTE_RESET;
      DISPLAY_DATA_PINS_OE <= 1'b0;
      DMA_REQ <= 1'b0;
    end
    else
    begin
      DISPLAY_STROBE <= strobe_on ? pol : !pol;
      REGISTER_SELECT_LINE <= op_rs;
      DISPLAY_DATA_PINS_O <= pin_byte;
      DISPLAY_DATA_PINS_OE <= drive_bus;
      DMA_REQ <= dma_en && !wr_pending && !wr_push_req;
    end
  end
endmodule : cdb_top
